// ### dv/pin_side_model.sv
// far-side model: timer clock pin and capture input source
`timescale 1ns/1ps
module pin_side_model (
    // clock
    input wire logic clk,
    // commands from the bench
    input wire logic capLevel,
    input wire logic [1:0] timerMode,
    // design side of the capture pin
    input wire logic capOutData,
    input wire logic capOutEn,
    // pins seen by the design
    output logic capWire,
    output logic timerPin
);
    logic capHeld = 1'b0;
    logic [1:0] holdCnt = 2'h0;
    logic [1:0] tog = 2'h0;
    always @(posedge clk) begin
        tog <= tog + 2'h1;
        if (holdCnt != 2'h0) begin
            holdCnt <= holdCnt - 2'h1;
        end else if (capLevel != capHeld) begin
            capHeld <= capLevel;
            holdCnt <= 2'h2;
        end
    end
    // mode 2 gives one rising edge every four clocks
    assign timerPin = (timerMode == 2'h2) ? tog[1] : timerMode[0];
    assign capWire = capOutEn ? capOutData : capHeld;
endmodule

// ### dv/tb_programmable_timer_two.sv
// self-checking bench of the second programmable timer
`timescale 1ns/1ps
module tb_programmable_timer_two;
    typedef struct packed {
        logic wr;
        logic [5:0] idx;
        logic [7:0] val;
    } row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic gMask = 1'b0;
    logic capLevel = 1'b0;
    logic [1:0] timerMode = 2'h0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] datO, rd;
    logic ack, ovfIrq, cmpIrq, capIrq, timerPin, capWire, capOutData, capOutEn, cmpPin, cmpEn;
    logic [1:0] vec;
    logic [7:0] dl;
    int errorCnt = 0;
    int checkCount = 0;
    int cycles = 0;
    row_t rows [18] = '{'{1'b0, timer_two_pkg::IDX_PRESCALE, 8'h10}, '{1'b0, timer_two_pkg::IDX_CONTROL, 8'h1C},
        '{1'b0, timer_two_pkg::IDX_COUNTER, 8'h00}, '{1'b0, timer_two_pkg::IDX_COMPARE, 8'hFF},
        '{1'b0, timer_two_pkg::IDX_CAPTURE, 8'h00}, '{1'b0, timer_two_pkg::IDX_PINS, 8'h00},
        '{1'b1, timer_two_pkg::IDX_PRESCALE, 8'hFF}, '{1'b0, timer_two_pkg::IDX_PRESCALE, 8'h37},
        '{1'b1, timer_two_pkg::IDX_COMPARE, 8'hA5}, '{1'b0, timer_two_pkg::IDX_COMPARE, 8'hA5},
        '{1'b1, timer_two_pkg::IDX_CAPTURE, 8'h55}, '{1'b0, timer_two_pkg::IDX_CAPTURE, 8'h00},
        '{1'b1, 6'h00, 8'h55}, '{1'b0, 6'h00, 8'h00}, '{1'b1, timer_two_pkg::IDX_FLAGS, 8'h00},
        '{1'b0, timer_two_pkg::IDX_FLAGS, 8'h20}, '{1'b1, timer_two_pkg::IDX_CONTROL, 8'h1F},
        '{1'b0, timer_two_pkg::IDX_CONTROL, 8'h1F}};

    timer_two dut (.clk(clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(dat), .dat_o(datO), .ack_o(ack), .globalIrqMask(gMask), .overflowInterrupt(ovfIrq),
        .compareInterrupt(cmpIrq), .captureInterrupt(capIrq), .irqVector(vec), .timerPin(timerPin),
        .captureInputPin(capWire), .captureOutData(capOutData), .captureOutEn(capOutEn),
        .compareOutputPin(cmpPin), .compareOutEn(cmpEn));

    pin_side_model far (.clk(clk), .capLevel(capLevel), .timerMode(timerMode), .capOutData(capOutData),
        .capOutEn(capOutEn), .capWire(capWire), .timerPin(timerPin));

    always #10 clk = ~clk;

    // ********
    // helpers
    // ********
    task automatic summarize();
        if (errorCnt == 0 && checkCount > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // whole run needs well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errorCnt++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // single plain accesses, no dummy reads, no read-modify-write on the flags
    task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] v, output logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= {idx, 2'b00};
        dat <= {24'h0, v};
        do @(posedge clk); while (ack !== 1'b1);
        d = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] v);
        wb(1'b1, idx, v, rd);
    endtask

    task automatic rdChk(input logic [5:0] idx, input logic [7:0] e);
        wb(1'b0, idx, 8'h00, rd);
        chk(rd, {24'h0, e});
    endtask

    // successive reads are taken three clocks apart, so gap counts from take to take
    task automatic span(input int gap, output logic [7:0] delta);
        logic [7:0] a;
        wb(1'b0, timer_two_pkg::IDX_COUNTER, 8'h00, rd);
        a = rd[7:0];
        repeat (gap - 3) @(posedge clk);
        wb(1'b0, timer_two_pkg::IDX_COUNTER, 8'h00, rd);
        delta = rd[7:0] - a;
    endtask

    task automatic waitHi(ref logic s);
        for (int i = 0; i < 300 && s !== 1'b1; i++) begin
            @(posedge clk);
        end
    endtask

    // ********
    // stimulus
    // ********
    initial begin
        repeat (6) @(posedge clk);
        chk({cmpEn, capOutEn, cmpPin}, 0);
        rst_n <= 1'b1;
        foreach (rows[k]) begin
            wb(rows[k].wr, rows[k].idx, rows[k].val, rd);
            if (!rows[k].wr) chk(rd, {24'h0, rows[k].val});
        end
        for (int n = 0; n < 8; n++) begin
            wr(timer_two_pkg::IDX_PRESCALE, n[7:0]);
            span(4 << n, dl);
            chk(dl, 4);
        end
        wr(timer_two_pkg::IDX_PRESCALE, 8'h10);
        span(20, dl);
        chk(dl, 0);
        timerMode <= 2'h1;
        span(20, dl);
        chk(dl, 20);
        wr(timer_two_pkg::IDX_PRESCALE, 8'h30);
        timerMode <= 2'h2;
        span(40, dl);
        chk(dl, 10);
        timerMode <= 2'h0;
        wr(timer_two_pkg::IDX_PRESCALE, 8'h07);
        wr(timer_two_pkg::IDX_COUNTER, 8'h80);
        repeat (10) @(posedge clk);
        rdChk(timer_two_pkg::IDX_COUNTER, 8'h81);
        repeat (60) @(posedge clk);
        rdChk(timer_two_pkg::IDX_COUNTER, 8'h81);
        // overflow: clear while frozen, then let it wrap
        wr(timer_two_pkg::IDX_PRESCALE, 8'h10);
        wr(timer_two_pkg::IDX_COUNTER, 8'h05);
        wr(timer_two_pkg::IDX_CONTROL, 8'h18);
        wb(1'b0, timer_two_pkg::IDX_FLAGS, 8'h00, rd);
        rdChk(timer_two_pkg::IDX_COUNTER, 8'h05);
        wb(1'b0, timer_two_pkg::IDX_FLAGS, 8'h00, rd);
        chk(rd[5], 0);
        wr(timer_two_pkg::IDX_FLAGS, 8'hE0);
        wb(1'b0, timer_two_pkg::IDX_FLAGS, 8'h00, rd);
        chk({rd[7], rd[5]}, 0);
        chk(ovfIrq, 0);
        wr(timer_two_pkg::IDX_PRESCALE, 8'h00);
        waitHi(ovfIrq);
        chk(ovfIrq, 1);
        wr(timer_two_pkg::IDX_CONTROL, 8'h1C);
        chk(ovfIrq, 0);
        // compare match drives the pin
        wr(timer_two_pkg::IDX_PRESCALE, 8'h10);
        wr(timer_two_pkg::IDX_COUNTER, 8'h00);
        wr(timer_two_pkg::IDX_PINS, 8'h04);
        chk(cmpEn, 1);
        wr(timer_two_pkg::IDX_CONTROL, 8'h15);
        wb(1'b0, timer_two_pkg::IDX_FLAGS, 8'h00, rd);
        wr(timer_two_pkg::IDX_COMPARE, 8'h40);
        chk({cmpIrq, cmpPin}, 0);
        wr(timer_two_pkg::IDX_PRESCALE, 8'h00);
        waitHi(cmpPin);
        chk({cmpIrq, cmpPin}, 3);
        chk(vec, timer_two_pkg::VEC_COMPARE);
        gMask <= 1'b1;
        repeat (2) @(posedge clk);
        chk({cmpIrq, vec}, {1'b0, timer_two_pkg::VEC_NONE});
        gMask <= 1'b0;
        wr(timer_two_pkg::IDX_PINS, 8'h04);
        chk(cmpPin, 0);
        wr(timer_two_pkg::IDX_CONTROL, 8'h1D);
        chk(cmpIrq, 0);
        // counter write reloads and steps each clock, so the pin write is taken as the count meets 40
        wr(timer_two_pkg::IDX_COUNTER, 8'h3E);
        wr(timer_two_pkg::IDX_PINS, 8'h04);
        chk(cmpPin, 1);
        // capture on each edge polarity, direction bit kept clear
        wr(timer_two_pkg::IDX_PRESCALE, 8'h10);
        wr(timer_two_pkg::IDX_CONTROL, 8'h0C);
        wr(timer_two_pkg::IDX_COUNTER, 8'h3C);
        capLevel <= 1'b1;
        repeat (8) @(posedge clk);
        rdChk(timer_two_pkg::IDX_CAPTURE, 8'h00);
        chk(capIrq, 0);
        capLevel <= 1'b0;
        repeat (8) @(posedge clk);
        rdChk(timer_two_pkg::IDX_CAPTURE, 8'h3C);
        chk({capIrq, vec}, {1'b1, timer_two_pkg::VEC_CAPTURE});
        wb(1'b0, timer_two_pkg::IDX_FLAGS, 8'h00, rd);
        wb(1'b0, timer_two_pkg::IDX_CONTROL, 8'h00, rd);
        chk(capIrq, 0);
        wr(timer_two_pkg::IDX_CONTROL, 8'h0E);
        wr(timer_two_pkg::IDX_COUNTER, 8'h7B);
        capLevel <= 1'b1;
        repeat (8) @(posedge clk);
        rdChk(timer_two_pkg::IDX_CAPTURE, 8'h7B);
        wr(timer_two_pkg::IDX_COUNTER, 8'h11);
        capLevel <= 1'b0;
        repeat (8) @(posedge clk);
        rdChk(timer_two_pkg::IDX_CAPTURE, 8'h7B);
        wr(timer_two_pkg::IDX_CONTROL, 8'h1E);
        chk(capIrq, 0);
        // capture pin driven only now, after the capture tests, so reset has both directions to clear
        wr(timer_two_pkg::IDX_PINS, 8'h0E);
        chk({capOutEn, capOutData, cmpEn}, 7);
        rdChk(timer_two_pkg::IDX_PINS, 8'h0E);
        // second reset in mid-run
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk({cmpEn, capOutEn, capOutData, cmpPin}, 0);
        rdChk(timer_two_pkg::IDX_CONTROL, 8'h1C);
        summarize();
    end
endmodule

// ### logic/prescale_if.sv
// carrier between the timer core and its prescaler
`timescale 1ns/1ps
interface prescale_if;
    logic srcPulse;
    logic reload;
    logic [2:0] divSel;
    logic tick;
    modport core (output srcPulse, output reload, output divSel, input tick);
    modport pre (input srcPulse, input reload, input divSel, output tick);
endinterface

// ### logic/timer_prescaler.sv
// seven-bit prescaler with power-of-two tap select
`timescale 1ns/1ps
module timer_prescaler (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link to the core
    prescale_if.pre ps
);
    logic [6:0] preQ;
    logic [6:0] preD;
    logic [6:0] tapMask;

    // divide select
    // tick when all selected low bits are ones, so a reload ticks on the first pulse
    always_comb begin
        tapMask = 7'((8'h01 << ps.divSel) - 8'h01);
        ps.tick = ps.srcPulse && ((preQ & tapMask) == tapMask);
        preD = preQ;
        if (ps.reload) begin
            preD = timer_two_pkg::PRESCALER_INIT;
        end else if (ps.srcPulse) begin
            preD = preQ + 7'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            preQ <= timer_two_pkg::PRESCALER_INIT;
        end else begin
            preQ <= preD;
        end
    end

    reload_all_ones_a: assert property (@(posedge clk) disable iff (!rst_n)
        ps.reload |=> preQ == 7'h7F)
        else $error("prescaler not reloaded");
    divide_one_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ps.srcPulse && ps.divSel == 3'h0) |-> ps.tick)
        else $error("divide by one missed a tick");
endmodule

// ### logic/timer_two.sv
// second programmable timer: counter, compare, capture and flags on Wishbone
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module timer_two (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // processor interrupt side
    input wire logic globalIrqMask,
    output logic overflowInterrupt,
    output logic compareInterrupt,
    output logic captureInterrupt,
    output logic [1:0] irqVector,
    // pins
    input wire logic timerPin,
    input wire logic captureInputPin,
    output logic captureOutData,
    output logic captureOutEn,
    output logic compareOutputPin,
    output logic compareOutEn
);
    prescale_if ps ();

    timer_prescaler u_pre (
        .clk(clk),
        .rst_n(rst_n),
        .ps(ps)
    );

    // ************************************************************
    // state
    // ************************************************************
    logic ackQ, ackD;
    logic [31:0] datQ, datD;
    logic [4:0] ctlQ, ctlD;
    logic [7:0] pcsQ, pcsD;
    logic [7:0] cntQ, cntD;
    logic [7:0] cmpQ, cmpD;
    logic [7:0] capQ, capD;
    logic [3:0] pinQ, pinD;
    logic [2:0] flgQ, flgD;
    logic [2:0] armQ, armD;
    logic matchQ, matchD;
    logic capPrevQ, capPrevD;
    logic tmrPrevQ, tmrPrevD;
    logic outQ, outD;

    logic access, wr, rd;
    logic [5:0] idx;
    logic match, matchEvt, capEvt, ovfSet;
    logic [7:0] flagsView, rdMux;
    logic [1:0] src;

    assign idx = adr_i[7:2];
    assign access = cyc_i && stb_i && !ackQ;
    assign wr = access && we_i && sel_i[0];
    assign rd = access && !we_i;

    // continuous compare, acted on when equality first appears
    assign match = cntQ == cmpQ;
    assign matchEvt = match && !matchQ;
    // overflow flag follows a zero counter
    assign ovfSet = cntQ == 8'h00;
    // edge select picks the capture edge
    assign capEvt = ctlQ[timer_two_pkg::CTL_EDGE] ? (captureInputPin && !capPrevQ)
                                                  : (!captureInputPin && capPrevQ);
    assign flagsView = {flgQ, 5'h00};
    assign src = {pcsQ[timer_two_pkg::PCS_SRC_HI], pcsQ[timer_two_pkg::PCS_SRC_LO]};

    // clock source select; the unlisted code 10 stops the count
    always_comb begin
        case (src)
            2'b00: ps.srcPulse = 1'b1;
            2'b01: ps.srcPulse = timerPin;
            2'b11: ps.srcPulse = timerPin && !tmrPrevQ;
            default: ps.srcPulse = 1'b0;
        endcase
    end
    assign ps.divSel = pcsQ[2:0];
    // reload on prescaler control or counter write
    assign ps.reload = wr && (idx == timer_two_pkg::IDX_PRESCALE || idx == timer_two_pkg::IDX_COUNTER);

    always_comb begin
        case (idx)
            timer_two_pkg::IDX_PRESCALE: rdMux = pcsQ;
            timer_two_pkg::IDX_FLAGS: rdMux = flagsView;
            timer_two_pkg::IDX_CONTROL: rdMux = {3'h0, ctlQ};
            timer_two_pkg::IDX_COUNTER: rdMux = cntQ;
            timer_two_pkg::IDX_COMPARE: rdMux = cmpQ;
            timer_two_pkg::IDX_CAPTURE: rdMux = capQ;
            timer_two_pkg::IDX_PINS: rdMux = {4'h0, pinQ[3:2], pinQ[timer_two_pkg::PIN_CAP_DATA], outQ};
            default: rdMux = 8'h00;
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        ackD = access;
        datD = rd ? {24'h000000, rdMux} : 32'h00000000;
        ctlD = ctlQ;
        pcsD = pcsQ;
        cntD = cntQ;
        cmpD = cmpQ;
        capD = capQ;
        pinD = pinQ;
        flgD = flgQ;
        armD = armQ;
        matchD = match;
        capPrevD = captureInputPin;
        tmrPrevD = timerPin;
        outD = outQ;
        // count on each prescaled tick, wrapping naturally
        if (ps.tick) begin
            cntD = cntQ + 8'h01;
        end
        // flag register takes no writes, only the others below
        if (wr) begin
            case (idx)
                timer_two_pkg::IDX_PRESCALE: pcsD = dat_i[7:0] & timer_two_pkg::PRESCALE_WMASK;
                timer_two_pkg::IDX_CONTROL: ctlD = dat_i[4:0];
                timer_two_pkg::IDX_COUNTER: cntD = dat_i[7:0];
                timer_two_pkg::IDX_COMPARE: cmpD = dat_i[7:0];
                timer_two_pkg::IDX_PINS: begin
                    pinD = dat_i[3:0];
                    // direct software write of the compare pin
                    outD = dat_i[timer_two_pkg::PIN_CMP_DATA];
                end
                default: ;
            endcase
        end
        // hardware level wins over a same-cycle software write
        if (matchEvt) begin
            outD = ctlQ[timer_two_pkg::CTL_LEVEL];
        end
        // latch counter on the chosen edge, sensed whatever the direction bit
        if (capEvt) begin
            capD = cntQ;
        end
        // clears first, so a set in the same cycle still wins
        if (rd && idx == timer_two_pkg::IDX_COUNTER && armQ[0]) begin
            flgD[0] = 1'b0;
            armD[0] = 1'b0;
        end
        if (wr && idx == timer_two_pkg::IDX_COMPARE && armQ[1]) begin
            flgD[1] = 1'b0;
            armD[1] = 1'b0;
        end
        if (rd && idx == timer_two_pkg::IDX_CONTROL && armQ[2]) begin
            flgD[2] = 1'b0;
            armD[2] = 1'b0;
        end
        // a flags read arms only the flags it saw set; dummy reads arm too, hence the software caution
        if (rd && idx == timer_two_pkg::IDX_FLAGS) begin
            armD = flgQ;
        end
        if (ovfSet) begin
            flgD[0] = 1'b1;
        end
        if (matchEvt) begin
            flgD[1] = 1'b1;
        end
        if (capEvt) begin
            flgD[2] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ackQ <= 1'b0;
            datQ <= 32'h00000000;
            ctlQ <= timer_two_pkg::CONTROL_RESET;
            pcsQ <= timer_two_pkg::PRESCALE_RESET;
            cntQ <= timer_two_pkg::COUNTER_RESET;
            cmpQ <= timer_two_pkg::COMPARE_RESET;
            capQ <= 8'h00;
            pinQ <= timer_two_pkg::PINS_RESET;
            flgQ <= 3'h0;
            armQ <= 3'h0;
            matchQ <= 1'b0;
            capPrevQ <= 1'b0;
            tmrPrevQ <= 1'b0;
            outQ <= 1'b0;
        end else begin
            ackQ <= ackD;
            datQ <= datD;
            ctlQ <= ctlD;
            pcsQ <= pcsD;
            cntQ <= cntD;
            cmpQ <= cmpD;
            capQ <= capD;
            pinQ <= pinD;
            flgQ <= flgD;
            armQ <= armD;
            matchQ <= matchD;
            capPrevQ <= capPrevD;
            tmrPrevQ <= tmrPrevD;
            outQ <= outD;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign ack_o = ackQ;
    assign dat_o = datQ;
    assign compareOutputPin = outQ;
    assign compareOutEn = pinQ[timer_two_pkg::PIN_CMP_DIR];
    assign captureOutData = pinQ[timer_two_pkg::PIN_CAP_DATA];
    assign captureOutEn = pinQ[timer_two_pkg::PIN_CAP_DIR];

    // masked requests, held low while the global mask is set
    assign overflowInterrupt = flgQ[0] && !ctlQ[timer_two_pkg::CTL_OVF_MASK] && !globalIrqMask;
    assign compareInterrupt = flgQ[1] && !ctlQ[timer_two_pkg::CTL_CMP_MASK] && !globalIrqMask;
    assign captureInterrupt = flgQ[2] && !ctlQ[timer_two_pkg::CTL_CAP_MASK] && !globalIrqMask;

    always_comb begin
        if (captureInterrupt) begin
            irqVector = timer_two_pkg::VEC_CAPTURE;
        end else if (compareInterrupt) begin
            irqVector = timer_two_pkg::VEC_COMPARE;
        end else if (overflowInterrupt) begin
            irqVector = timer_two_pkg::VEC_OVERFLOW;
        end else begin
            irqVector = timer_two_pkg::VEC_NONE;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    match_drives_pin_a: assert property (matchEvt |=> outQ == $past(ctlQ[0]))
        else $error("compare pin did not take the level bit");
    capture_latch_a: assert property (capEvt |=> capQ == $past(cntQ) && flgQ[2])
        else $error("capture did not latch the counter");
    overflow_req_a: assert property (overflowInterrupt == (flgQ[0] && !ctlQ[2] && !globalIrqMask))
        else $error("overflow request wrong");
    compare_req_a: assert property (compareInterrupt |-> flgQ[1] && !ctlQ[3])
        else $error("compare request without flag");
    capture_req_a: assert property (captureInterrupt |-> flgQ[2] && !ctlQ[4])
        else $error("capture request without flag");
    flags_readonly_a: assert property ((wr && idx == 6'h1A && !ovfSet && !matchEvt && !capEvt && !rd)
        |=> flgQ == $past(flgQ))
        else $error("flag register changed on write");
    global_mask_a: assert property (globalIrqMask |-> irqVector == 2'h0)
        else $error("vector while globally masked");
    // the release edge still shows the reset state, so the zero counter starts an attempt there
    overflow_set_a: assert property (rst_n && cntQ == 8'h00 |=> flgQ[0])
        else $error("overflow flag not set at zero");
    compare_clear_a: assert property ((wr && idx == 6'h1D && armQ[1] && !matchEvt) |=> !flgQ[1])
        else $error("compare flag not cleared");
    capture_clear_a: assert property ((rd && idx == 6'h1B && armQ[2] && !capEvt) |=> !flgQ[2])
        else $error("capture flag not cleared");
    counter_wrap_a: assert property ((ps.tick && !wr && cntQ == 8'hFF) |=> cntQ == 8'h00 ##1 flgQ[0])
        else $error("counter did not wrap");
    write_loses_a: assert property ((wr && idx == 6'h1F && matchEvt) |=> outQ == $past(ctlQ[0]))
        else $error("software write beat the match");
    bus_ack_a: assert property ((cyc_i && stb_i && !ackQ) |=> ack_o ##1 !ack_o)
        else $error("ack not a single cycle");
    // register writes land at the taking edge, so their effect is looked at one cycle later
    pin_write_a: assert property ((wr && idx == 6'h1F && !matchEvt) |=> outQ == $past(dat_i[0]))
        else $error("compare pin did not take the written level");
    counter_write_a: assert property ((wr && idx == 6'h1C) |=> cntQ == $past(dat_i[7:0]))
        else $error("counter write lost");
    compare_load_a: assert property ((wr && idx == 6'h1D) |=> cmpQ == $past(dat_i[7:0]))
        else $error("compare write lost");
    prescale_write_a: assert property ((wr && idx == 6'h19) |=> pcsQ == ($past(dat_i[7:0]) & 8'h37))
        else $error("prescaler control write wrong");
    overflow_clear_a: assert property ((rd && idx == 6'h1C && armQ[0] && !ovfSet) |=> !flgQ[0])
        else $error("overflow flag not cleared");
    capture_hold_a: assert property (!capEvt |=> capQ == $past(capQ))
        else $error("captured value moved without an edge");
    // a low gate pin must freeze the count, or measured pulse widths come out long
    count_gate_a: assert property ((pcsQ[5:4] == 2'b01 && !timerPin && !wr) |=> cntQ == $past(cntQ))
        else $error("gated count moved while the pin was low");
    vector_priority_a: assert property (captureInterrupt |-> irqVector == 2'h1)
        else $error("capture request lost its priority");

    overflow_seen_c: cover property (ovfSet && !flgQ[0]);
    capture_seen_c: cover property (capEvt);
    match_seen_c: cover property (matchEvt && compareOutEn);
    flag_cleared_c: cover property (flgQ[1] ##1 !flgQ[1]);
    write_lost_c: cover property (wr && idx == 6'h1F && matchEvt);
endmodule

// ### logic/timer_two_pkg.sv
// constants and register layout of the second programmable timer
package timer_two_pkg;
    // ************************************************************
    // register indices, byte address is four times the index
    // ************************************************************
    localparam logic [5:0] IDX_PRESCALE = 6'h19;
    localparam logic [5:0] IDX_FLAGS = 6'h1A;
    localparam logic [5:0] IDX_CONTROL = 6'h1B;
    localparam logic [5:0] IDX_COUNTER = 6'h1C;
    localparam logic [5:0] IDX_COMPARE = 6'h1D;
    localparam logic [5:0] IDX_CAPTURE = 6'h1E;
    localparam logic [5:0] IDX_PINS = 6'h1F;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTL_LEVEL = 0;
    localparam int CTL_EDGE = 1;
    localparam int CTL_OVF_MASK = 2;
    localparam int CTL_CMP_MASK = 3;
    localparam int CTL_CAP_MASK = 4;
    localparam int FLG_OVF = 5;
    localparam int FLG_CMP = 6;
    localparam int FLG_CAP = 7;
    localparam int PCS_SRC_LO = 4;
    localparam int PCS_SRC_HI = 5;
    localparam int PIN_CMP_DATA = 0;
    localparam int PIN_CAP_DATA = 1;
    localparam int PIN_CMP_DIR = 2;
    localparam int PIN_CAP_DIR = 3;
    // ************************************************************
    // reset values and widths
    // ************************************************************
    localparam logic [4:0] CONTROL_RESET = 5'h1C;
    localparam logic [7:0] PRESCALE_RESET = 8'h10;
    localparam logic [7:0] PRESCALE_WMASK = 8'h37;
    localparam logic [7:0] COMPARE_RESET = 8'hFF;
    localparam logic [7:0] COUNTER_RESET = 8'h00;
    localparam logic [6:0] PRESCALER_INIT = 7'h7F;
    localparam logic [3:0] PINS_RESET = 4'h0;
    // vector codes, capture highest priority
    localparam logic [1:0] VEC_NONE = 2'h0;
    localparam logic [1:0] VEC_CAPTURE = 2'h1;
    localparam logic [1:0] VEC_COMPARE = 2'h2;
    localparam logic [1:0] VEC_OVERFLOW = 2'h3;
endpackage
